// *** hdl/bss_pkg.sv ***
// constants and types shared by the start-up sequencer
package bss_pkg;

  // ---------------------------------------------------------------
  // modes and commutation states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BSS_ALIGN = 3'b001,
    BSS_RAMP  = 3'b010,
    BSS_RUN   = 3'b100
  } bss_mode_e;

  typedef enum logic [6:0] {
    BSS_ST_R = 7'b0000001,
    BSS_ST_A = 7'b0000010,
    BSS_ST_B = 7'b0000100,
    BSS_ST_C = 7'b0001000,
    BSS_ST_D = 7'b0010000,
    BSS_ST_E = 7'b0100000,
    BSS_ST_F = 7'b1000000
  } bss_comm_e;

  // gate pattern order: {lower3, lower2, lower1, upper3, upper2, upper1}
  localparam logic [5:0] BSS_GATES_R   = 6'h15;
  localparam logic [5:0] BSS_GATES_A   = 6'h21;
  localparam logic [5:0] BSS_GATES_B   = 6'h22;
  localparam logic [5:0] BSS_GATES_C   = 6'h0A;
  localparam logic [5:0] BSS_GATES_D   = 6'h0C;
  localparam logic [5:0] BSS_GATES_E   = 6'h14;
  localparam logic [5:0] BSS_GATES_F   = 6'h11;
  localparam logic [5:0] BSS_GATES_OFF = 6'h00;
  localparam int         BSS_LOW3_BIT  = 5;

  // sampled phase code: 0 none, 1 phase1, 2 phase2, 3 phase3
  localparam logic [1:0] BSS_SMP_NONE = 2'h0;
  localparam logic [1:0] BSS_SMP_P1   = 2'h1;
  localparam logic [1:0] BSS_SMP_P2   = 2'h2;
  localparam logic [1:0] BSS_SMP_P3   = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int BSS_CLK_MHZ       = 125;
  localparam int BSS_OFF_TIME_US   = 20;
  localparam int BSS_OFF_TIME_CYC  = BSS_OFF_TIME_US * BSS_CLK_MHZ;
  localparam int BSS_PWM_PERIOD_US = 40;
  localparam int BSS_PWM_CYC       = BSS_PWM_PERIOD_US * BSS_CLK_MHZ;

endpackage : bss_pkg

// *** hdl/bss_one_shot.sv ***
// retriggerable countdown one-shot with fixed length
`timescale 1ns/100ps
module bss_one_shot #(
  parameter int LEN_CYC = 8
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // trigger and output
  input  wire logic fire_i,
  output logic      busy_o
);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  localparam int CW = $clog2(LEN_CYC + 1);
  localparam logic [CW-1:0] LEN = CW'(LEN_CYC);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt_q;

  initial begin
    if (LEN_CYC < 1) $error("bss_one_shot: LEN_CYC must be >= 1");
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (fire_i) begin
      cnt_q <= LEN;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - ONE;
    end
  end

  assign busy_o = (cnt_q != '0);

endmodule : bss_one_shot

// *** hdl/bss_sequencer.sv ***
// start-up sequencer, commutation and gate-output logic
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/100ps
module bss_sequencer #(
  parameter int OFF_TIME_CYC = bss_pkg::BSS_OFF_TIME_CYC,
  parameter int PWM_CYC      = bss_pkg::BSS_PWM_CYC,
  parameter int ERR_W        = 16
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  // timing comparators
  input  wire logic             align_trip_i,
  input  wire logic             ramp_trip_i,
  input  wire logic             comm_clk_i,
  // speed loop and current limit
  input  wire logic [ERR_W-1:0] speed_error_i,
  input  wire logic             current_trip_i,
  // protection inputs
  input  wire logic             upper3_high_i,
  input  wire logic             brake_request_n_i,
  input  wire logic             undervoltage_i,
  // bridge gate outputs
  output logic                  lower_gate_1_o,
  output logic                  lower_gate_2_o,
  output logic                  lower_gate_3_o,
  output logic                  upper_gate_1_o,
  output logic                  upper_gate_2_o,
  output logic                  upper_gate_3_o,
  // status and analog controls
  output logic                  undervoltage_flag_n_o,
  output logic                  emf_sampler_en_o,
  output logic                  ramp_charge_en_o,
  output logic [1:0]            sample_select_o,
  output logic [2:0]            mode_o
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  initial begin
    if (PWM_CYC < 2) $error("bss_sequencer: PWM_CYC must be >= 2");
    if (OFF_TIME_CYC < 2) $error("bss_sequencer: OFF_TIME_CYC too small");
    if ($clog2(PWM_CYC) > ERR_W) $error("bss_sequencer: ERR_W too small");
  end

  // ---------------------------------------------------------------
  // mode sequence
  // ---------------------------------------------------------------
  bss_pkg::bss_mode_e mode_q;
  logic               enter_ramp;

  assign enter_ramp = (mode_q == bss_pkg::BSS_ALIGN) && align_trip_i;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_q <= bss_pkg::BSS_ALIGN;
    end else begin
      case (mode_q)
        bss_pkg::BSS_ALIGN: begin
          if (align_trip_i) mode_q <= bss_pkg::BSS_RAMP;
        end
        bss_pkg::BSS_RAMP: begin
          if (ramp_trip_i) mode_q <= bss_pkg::BSS_RUN;
        end
        bss_pkg::BSS_RUN: begin
          mode_q <= bss_pkg::BSS_RUN;
        end
        default: mode_q <= bss_pkg::BSS_ALIGN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // commutation state machine
  // ---------------------------------------------------------------
  // oscillator treated as synchronous level; rising edge steps state
  logic              comm_clk_q;
  logic              comm_step;
  bss_pkg::bss_comm_e comm_q;

  assign comm_step = comm_clk_i && !comm_clk_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      comm_clk_q <= 1'b0;
    end else begin
      comm_clk_q <= comm_clk_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      comm_q <= bss_pkg::BSS_ST_R;
    end else if (enter_ramp) begin
      comm_q <= bss_pkg::BSS_ST_A;
    end else if (mode_q != bss_pkg::BSS_ALIGN && comm_step) begin
      case (comm_q)
        bss_pkg::BSS_ST_A: comm_q <= bss_pkg::BSS_ST_B;
        bss_pkg::BSS_ST_B: comm_q <= bss_pkg::BSS_ST_C;
        bss_pkg::BSS_ST_C: comm_q <= bss_pkg::BSS_ST_D;
        bss_pkg::BSS_ST_D: comm_q <= bss_pkg::BSS_ST_E;
        bss_pkg::BSS_ST_E: comm_q <= bss_pkg::BSS_ST_F;
        bss_pkg::BSS_ST_F: comm_q <= bss_pkg::BSS_ST_A;
        default:           comm_q <= bss_pkg::BSS_ST_A;
      endcase
    end
  end

  // table lookup of gate pattern and sampled phase
  logic [5:0] table_gates;
  logic [1:0] table_smp;

  always_comb begin
    case (comm_q)
      bss_pkg::BSS_ST_R: begin
        table_gates = bss_pkg::BSS_GATES_R;
        table_smp   = bss_pkg::BSS_SMP_NONE;
      end
      bss_pkg::BSS_ST_A: begin
        table_gates = bss_pkg::BSS_GATES_A;
        table_smp   = bss_pkg::BSS_SMP_P2;
      end
      bss_pkg::BSS_ST_B: begin
        table_gates = bss_pkg::BSS_GATES_B;
        table_smp   = bss_pkg::BSS_SMP_P1;
      end
      bss_pkg::BSS_ST_C: begin
        table_gates = bss_pkg::BSS_GATES_C;
        table_smp   = bss_pkg::BSS_SMP_P3;
      end
      bss_pkg::BSS_ST_D: begin
        table_gates = bss_pkg::BSS_GATES_D;
        table_smp   = bss_pkg::BSS_SMP_P2;
      end
      bss_pkg::BSS_ST_E: begin
        table_gates = bss_pkg::BSS_GATES_E;
        table_smp   = bss_pkg::BSS_SMP_P1;
      end
      bss_pkg::BSS_ST_F: begin
        table_gates = bss_pkg::BSS_GATES_F;
        table_smp   = bss_pkg::BSS_SMP_P3;
      end
      default: begin
        table_gates = bss_pkg::BSS_GATES_OFF;
        table_smp   = bss_pkg::BSS_SMP_NONE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // pwm sawtooth and duty
  // ---------------------------------------------------------------
  // count 0 stands for the ramp bottom, PWM_CYC-1 for its top
  localparam logic [ERR_W-1:0] SAW_TOP = ERR_W'(PWM_CYC - 1);
  localparam logic [ERR_W-1:0] SAW_ONE = ERR_W'(1);

  logic [ERR_W-1:0] saw_q;
  logic             pwm_on;

  always_ff @(posedge clock_i) begin
    if (rst_i || saw_q == SAW_TOP) begin
      saw_q <= '0;
    end else begin
      saw_q <= saw_q + SAW_ONE;
    end
  end

  assign pwm_on = speed_error_i > saw_q;

  // ---------------------------------------------------------------
  // current limit one-shot and cross-conduction hold
  // ---------------------------------------------------------------
  logic braking;
  logic off_busy;
  logic hold_q;

  assign braking = !brake_request_n_i;

  bss_one_shot #(
    .LEN_CYC (OFF_TIME_CYC)
  ) u_off_time (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .fire_i  (current_trip_i),
    .busy_o  (off_busy)
  );

  // set on the R to A step wins over a same-cycle release
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= enter_ramp || (hold_q && !upper3_high_i);
    end
  end

  // ---------------------------------------------------------------
  // output gating and registers
  // ---------------------------------------------------------------
  logic [5:0] gates_d;
  logic [5:0] gates_q;
  logic       lower_en;

  // undervoltage first, then brake: overcurrent must not interrupt a brake
  assign lower_en = pwm_on && !off_busy;

  always_comb begin
    gates_d = table_gates;
    if (undervoltage_i) begin
      gates_d = bss_pkg::BSS_GATES_OFF;
    end else if (braking) begin
      gates_d = {3'h7, 3'h0};
    end else begin
      gates_d[5:3] = table_gates[5:3] & {3{lower_en}};
      if (hold_q || enter_ramp) begin
        gates_d[bss_pkg::BSS_LOW3_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gates_q <= bss_pkg::BSS_GATES_OFF;
    end else begin
      gates_q <= gates_d;
    end
  end

  assign {lower_gate_3_o, lower_gate_2_o, lower_gate_1_o,
          upper_gate_3_o, upper_gate_2_o, upper_gate_1_o} = gates_q;

  // status and analog control registers
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      undervoltage_flag_n_o <= 1'b1;
      emf_sampler_en_o      <= 1'b0;
      ramp_charge_en_o      <= 1'b0;
      sample_select_o       <= bss_pkg::BSS_SMP_NONE;
      mode_o                <= bss_pkg::BSS_ALIGN;
    end else begin
      undervoltage_flag_n_o <= !undervoltage_i;
      emf_sampler_en_o      <= (mode_q == bss_pkg::BSS_RUN);
      ramp_charge_en_o      <= (mode_q == bss_pkg::BSS_RAMP);
      sample_select_o       <= table_smp;
      mode_o                <= mode_q;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_align_end;
    mode_q == bss_pkg::BSS_ALIGN && align_trip_i;
  endsequence

  sequence s_ramp_begin;
    mode_q == bss_pkg::BSS_RAMP && comm_q == bss_pkg::BSS_ST_A;
  endsequence

  reset_align_a: assert property (
    $fell(rst_i) |-> mode_q == bss_pkg::BSS_ALIGN)
    else $error("mode not align after reset");

  align_pattern_a: assert property (
    mode_q == bss_pkg::BSS_ALIGN && !undervoltage_i && !braking && lower_en
    |=> gates_q == bss_pkg::BSS_GATES_R)
    else $error("align gate pattern wrong");

  align_to_ramp_a: assert property (
    s_align_end |=> s_ramp_begin)
    else $error("align end did not start ramp at A");

  ramp_to_run_a: assert property (
    mode_q == bss_pkg::BSS_RAMP && ramp_trip_i |=> mode_q == bss_pkg::BSS_RUN)
    else $error("ramp end missed");

  ramp_controls_a: assert property (
    mode_q == bss_pkg::BSS_RAMP |=> ramp_charge_en_o && !emf_sampler_en_o)
    else $error("ramp controls wrong");

  comm_step_a: assert property (
    mode_q != bss_pkg::BSS_ALIGN && comm_q == bss_pkg::BSS_ST_C && comm_step
    |=> comm_q == bss_pkg::BSS_ST_D)
    else $error("commutation step wrong");

  brake_gates_a: assert property (
    braking && !undervoltage_i |=> gates_q == {3'h7, 3'h0})
    else $error("brake pattern wrong");

  uv_off_a: assert property (
    undervoltage_i
    |=> gates_q == bss_pkg::BSS_GATES_OFF && !undervoltage_flag_n_o)
    else $error("undervoltage did not clear gates");

  off_time_a: assert property (
    current_trip_i ##1 !braking [*2]
    |-> gates_q[5:3] == 3'h0 ##1 gates_q[5:3] == 3'h0)
    else $error("off-time did not hold lowers off");

  cross_hold_a: assert property (
    s_align_end ##1 !upper3_high_i ##1 !upper3_high_i && !braking
    |=> !lower_gate_3_o)
    else $error("lower3 not held off");

  run_sticky_a: assert property (
    mode_q == bss_pkg::BSS_RUN |=> mode_q == bss_pkg::BSS_RUN)
    else $error("run mode left");

endmodule : bss_sequencer

// *** tb/bss_bridge_model.sv ***
// bridge stage model: slow high-side turn-off on phase three
`timescale 1ns/100ps
module bss_bridge_model #(
  parameter int DLY = 4
) (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // gate drives
  input  wire logic       lower_gate_3_i,
  input  wire logic       upper_gate_3_i,
  // feedback
  output logic            upper3_high_o,
  output logic [7:0]      shoot_o
);
  // --------------------
  // phase three
  // --------------------
  logic [3:0] off_q;

  // high side keeps conducting until its node has risen
  always_ff @(posedge clock_i) begin
    if (rst_i || upper_gate_3_i)
      off_q <= 4'h0;
    else if (off_q < DLY)
      off_q <= off_q + 4'h1;
  end

  assign upper3_high_o = (off_q >= DLY);

  // counts cycles where both devices of phase three conduct
  always_ff @(posedge clock_i) begin
    if (rst_i)
      shoot_o <= 8'h00;
    else if (lower_gate_3_i && !upper3_high_o)
      shoot_o <= shoot_o + 8'h01;
  end
endmodule : bss_bridge_model

// *** tb/bss_sequencer_tb.sv ***
// self-checking bench for the start-up sequencer
`timescale 1ns/100ps
module bss_sequencer_tb;
  // --------------------
  // signals
  // --------------------
  localparam int OFF = 8;
  localparam int PWM = 16;
  logic        clk;
  logic        rst;
  logic        al_trip;
  logic        rp_trip;
  logic        comm;
  logic [15:0] err;
  logic        cur;
  logic        brk_n;
  logic        uv;
  logic        u3_high;
  logic [5:0]  gates;
  logic        uv_n;
  logic        emf_en;
  logic        chg_en;
  logic [1:0]  smp;
  logic [2:0]  mode;
  logic [7:0]  shoot;
  logic [5:0]  tab [6];
  logic [1:0]  stab [6];
  int          err_total;
  int          tests_run;

  bss_sequencer #(.OFF_TIME_CYC(OFF), .PWM_CYC(PWM)) u_dut (
    .clock_i(clk), .rst_i(rst), .align_trip_i(al_trip),
    .ramp_trip_i(rp_trip), .comm_clk_i(comm), .speed_error_i(err),
    .current_trip_i(cur), .upper3_high_i(u3_high),
    .brake_request_n_i(brk_n), .undervoltage_i(uv),
    .lower_gate_1_o(gates[3]), .lower_gate_2_o(gates[4]),
    .lower_gate_3_o(gates[5]), .upper_gate_1_o(gates[0]),
    .upper_gate_2_o(gates[1]), .upper_gate_3_o(gates[2]),
    .undervoltage_flag_n_o(uv_n), .emf_sampler_en_o(emf_en),
    .ramp_charge_en_o(chg_en), .sample_select_o(smp), .mode_o(mode));

  bss_bridge_model u_bridge (
    .clock_i(clk), .rst_i(rst), .lower_gate_3_i(gates[5]),
    .upper_gate_3_i(gates[2]), .upper3_high_o(u3_high),
    .shoot_o(shoot));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // --------------------
  // helpers
  // --------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input string nm, input logic [7:0] got,
                       input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task automatic do_reset;
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(2);
  endtask : do_reset

  // steps all six states; sampler code only meaningful in run
  task automatic step_all(input logic run);
    int i;
    for (i = 1; i <= 6; i++) begin
      comm = 1'b1;
      tick(1);
      comm = 1'b0;
      tick(3);
      check("gates", {2'h0, gates}, {2'h0, tab[i % 6]});
      if (run)
        check("sample", {6'h0, smp}, {6'h0, stab[i % 6]});
    end
  endtask : step_all

  // --------------------
  // scenarios
  // --------------------
  task automatic t_align;
    check("mode", {5'h0, mode}, 8'h01);
    check("gates", {2'h0, gates}, {2'h0, bss_pkg::BSS_GATES_R});
    check("uv_n", {7'h0, uv_n}, 8'h01);
    check("sample", {6'h0, smp}, {6'h0, bss_pkg::BSS_SMP_NONE});
    comm = 1'b1;
    rp_trip = 1'b1;
    tick(1);
    comm = 1'b0;
    rp_trip = 1'b0;
    tick(3);
    check("gates", {2'h0, gates}, {2'h0, bss_pkg::BSS_GATES_R});
    check("mode", {5'h0, mode}, 8'h01);
  endtask : t_align

  task automatic t_ramp;
    int i;
    int n;
    al_trip = 1'b1;
    tick(2);
    check("mode", {5'h0, mode}, 8'h02);
    check("charge", {6'h0, chg_en, emf_en}, 8'h02);
    check("lower3", {7'h0, gates[5]}, 8'h00);
    for (i = 0; i < 50 && gates[5] !== 1'b1; i++)
      tick(1);
    check("gates", {2'h0, gates}, {2'h0, bss_pkg::BSS_GATES_A});
    check("shoot", shoot, 8'h00);
    err = 16'h0008;
    tick(3);
    n = 0;
    for (i = 0; i < PWM; i++) begin
      n += gates[5];
      tick(1);
    end
    check("duty", n[7:0], 8'(PWM / 2));
    err = 16'h00FF;
    step_all(1'b0);
  endtask : t_ramp

  task automatic t_run;
    rp_trip = 1'b1;
    tick(3);
    check("mode", {5'h0, mode}, 8'h04);
    check("charge", {6'h0, chg_en, emf_en}, 8'h01);
    step_all(1'b1);
    check("mode", {5'h0, mode}, 8'h04);
  endtask : t_run

  task automatic t_current;
    int n;
    cur = 1'b1;
    tick(1);
    cur = 1'b0;
    tick(1);
    check("gates", {2'h0, gates}, 8'h01);
    n = 0;
    while (gates[5] === 1'b0 && n < 40) begin
      n++;
      tick(1);
    end
    check("off_time", {7'h0, n >= OFF && n <= OFF + 1}, 8'h01);
  endtask : t_current

  task automatic t_brake;
    err = 16'h0000;
    brk_n = 1'b0;
    cur = 1'b1;
    tick(3);
    check("gates", {2'h0, gates}, 8'h38);
    cur = 1'b0;
    brk_n = 1'b1;
    tick(3);
    check("gates", {2'h0, gates}, 8'h01);
    err = 16'h00FF;
  endtask : t_brake

  task automatic t_uv;
    brk_n = 1'b0;
    uv = 1'b1;
    tick(3);
    check("gates", {2'h0, gates}, 8'h00);
    check("uv_n", {7'h0, uv_n}, 8'h00);
    uv = 1'b0;
    brk_n = 1'b1;
    tick(3);
    check("uv_n", {7'h0, uv_n}, 8'h01);
    check("gates", {2'h0, gates}, {2'h0, bss_pkg::BSS_GATES_A});
  endtask : t_uv

  // --------------------
  // main sequence
  // --------------------
  initial begin
    {rst, al_trip, rp_trip, comm, cur, uv} = 6'h20;
    brk_n = 1'b1;
    err = 16'h00FF;
    err_total = 0;
    tests_run = 0;
    tab = '{bss_pkg::BSS_GATES_A, bss_pkg::BSS_GATES_B,
            bss_pkg::BSS_GATES_C, bss_pkg::BSS_GATES_D,
            bss_pkg::BSS_GATES_E, bss_pkg::BSS_GATES_F};
    stab = '{bss_pkg::BSS_SMP_P2, bss_pkg::BSS_SMP_P1,
             bss_pkg::BSS_SMP_P3, bss_pkg::BSS_SMP_P2,
             bss_pkg::BSS_SMP_P1, bss_pkg::BSS_SMP_P3};
    do_reset();
    t_align();
    t_ramp();
    t_run();
    t_current();
    t_brake();
    t_uv();
    al_trip = 1'b0;
    rp_trip = 1'b0;
    do_reset();
    t_align();
    test_done();
  end
endmodule : bss_sequencer_tb
